// *** ppp_defines.vh ***
`ifndef PPP_DEFINES_VH
`define PPP_DEFINES_VH

// -----------------------------------------------------------------
// Overlay select codes
// -----------------------------------------------------------------
`define PPP_OVL_PALETTE 2'h0
`define PPP_OVL_COLOR1 2'h1
`define PPP_OVL_COLOR2 2'h2
`define PPP_OVL_COLOR3 2'h3

// -----------------------------------------------------------------
// Colour word layout
// -----------------------------------------------------------------
`define PPP_RED_MSB 23
`define PPP_RED_LSB 16
`define PPP_GRN_MSB 15
`define PPP_GRN_LSB 8
`define PPP_BLU_MSB 7
`define PPP_BLU_LSB 0

// -----------------------------------------------------------------
// Levels, reset values and pipeline latency
// -----------------------------------------------------------------
`define PPP_BLACK_BYTE 8'h00
`define PPP_RST_WORD 24'h000000
`define PPP_PIPE_LATENCY 3

`endif

// *** ppp_skid_buffer.v ***
`timescale 1ns/1ps
// -----------------------------------------------------------------
// Two-entry buffer with valid/ready on both sides
// -----------------------------------------------------------------
module ppp_skid_buffer #(
	parameter WIDTH = 28
) (
	input wire core_clk_in,
	input wire rst_n_in,
	input wire in_valid_in,
	output wire in_ready_out,
	input wire [WIDTH-1:0] in_data_in,
	output wire out_valid_out,
	input wire out_ready_in,
	output wire [WIDTH-1:0] out_data_out
);
	reg [WIDTH-1:0] mem_r [0:1];
	reg wr_ptr_r;
	reg rd_ptr_r;
	reg [1:0] count_r;
	wire push;
	wire pop;

	assign in_ready_out = (count_r != 2'h2);
	assign out_valid_out = (count_r != 2'h0);
	assign out_data_out = mem_r[rd_ptr_r];
	assign push = in_valid_in && in_ready_out;
	assign pop = out_valid_out && out_ready_in;

	always @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			wr_ptr_r <= 1'b0;
			rd_ptr_r <= 1'b0;
			count_r <= 2'h0;
			mem_r[0] <= {WIDTH{1'b0}};
			mem_r[1] <= {WIDTH{1'b0}};
		end else begin
			if (push) begin
				mem_r[wr_ptr_r] <= in_data_in;
				wr_ptr_r <= ~wr_ptr_r;
			end
			if (pop)
				rd_ptr_r <= ~rd_ptr_r;
			if (push && !pop)
				count_r <= count_r + 2'h1;
			else if (pop && !push)
				count_r <= count_r - 2'h1;
		end
	end
endmodule

// *** ppp_pixel_port.v ***
`timescale 1ns/1ps
// Behaviour
// R1 - Capture pixel index and overlay select every clock edge to choose colour; the code skips capture on edges where stall is high.
// R2 - Overlay select zero reads palette entry addressed by captured pixel index.
// R3 - Overlay select one to three outputs that overlay colour, index ignored.
// R4 - Each colour word is 24 bits: red, green, blue bytes to converters.
// R5 - Sync and blank sampled on same edge and kept aligned with colour.
// R6 - Blank low disregards colour; sync low with blank gives sync level.
// R7 - Driving system holds sync low when sync is not encoded on green.
// R8 - Chip select low makes the block ignore pixel index and overlay select.
// R9 - Chip select low forces all three colour outputs to black.
// R10 - One fixed latency from capture to converter for all paths; the code lets words wait in the buffer while dac_ready_in is low.
`include "ppp_defines.vh"

module ppp_pixel_port #(
	parameter ENTRIES = 256,
	parameter IDX_W = 8
) (
	input wire core_clk_in,
	input wire reset_n_in,
	input wire [IDX_W-1:0] pixel_index_in,
	input wire overlay_select_lsb_in,
	input wire overlay_select_msb_in,
	input wire sync_n_in,
	input wire blank_n_in,
	input wire cs_n_in,
	input wire pal_wr_en_in,
	input wire [IDX_W-1:0] pal_wr_addr_in,
	input wire ovl_wr_en_in,
	input wire [1:0] ovl_wr_sel_in,
	input wire [23:0] wr_data_in,
	input wire dac_ready_in,
	output wire pix_ready_out,
	output wire dac_valid_out,
	output wire [7:0] red_current_out,
	output wire [7:0] green_current_out,
	output wire [7:0] blue_current_out,
	output wire sync_current_out,
	output wire blank_n_out
);
	// -----------------------------------------------------------------
	// Reset release
	// -----------------------------------------------------------------
	// Only the second flop of the release chain is read by the rest of the block.
	reg rst_meta_r;
	reg rst_n_r;
	always @(posedge core_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			rst_meta_r <= 1'b0;
			rst_n_r <= 1'b0;
		end else begin
			rst_meta_r <= 1'b1;
			rst_n_r <= rst_meta_r;
		end
	end

	// -----------------------------------------------------------------
	// Palette and overlay storage
	// -----------------------------------------------------------------
	// A palette write lands on the edge after its strobe.
	reg [23:0] pal_r [0:ENTRIES-1];
	reg [23:0] ovl_r [1:3];
	genvar gi;
	generate
		for (gi = 0; gi < ENTRIES; gi = gi + 1) begin : g_pal
			always @(posedge core_clk_in or negedge rst_n_r) begin
				if (!rst_n_r)
					pal_r[gi] <= `PPP_RST_WORD;
				else if (pal_wr_en_in && pal_wr_addr_in == gi)
					pal_r[gi] <= wr_data_in;
			end
		end
		for (gi = 1; gi < 4; gi = gi + 1) begin : g_ovl
			always @(posedge core_clk_in or negedge rst_n_r) begin
				if (!rst_n_r)
					ovl_r[gi] <= `PPP_RST_WORD;
				else if (ovl_wr_en_in && ovl_wr_sel_in == gi)
					ovl_r[gi] <= wr_data_in;
			end
		end
	endgenerate

	// -----------------------------------------------------------------
	// Stage 1: input capture
	// -----------------------------------------------------------------
	wire stall;
	reg s1_vld_r;
	reg [IDX_W-1:0] s1_idx_r;
	reg [IDX_W-1:0] s1_idx_nxt;
	reg [1:0] s1_ovl_r;
	reg [1:0] s1_ovl_nxt;
	reg s1_sync_n_r;
	reg s1_blank_n_r;
	reg s1_cs_n_r;
	// A full buffer freezes both stages, so no captured pixel is overwritten.
	assign pix_ready_out = !stall;

	// R8 chip select masks
	always @* begin
		s1_idx_nxt = pixel_index_in;
		s1_ovl_nxt = {overlay_select_msb_in, overlay_select_lsb_in};
		if (!cs_n_in) begin
			s1_idx_nxt = {IDX_W{1'b0}};
			s1_ovl_nxt = `PPP_OVL_PALETTE;
		end
	end

	always @(posedge core_clk_in or negedge rst_n_r) begin
		if (!rst_n_r) begin
			s1_vld_r <= 1'b0;
			s1_idx_r <= {IDX_W{1'b0}};
			s1_ovl_r <= `PPP_OVL_PALETTE;
			s1_sync_n_r <= 1'b0;
			s1_blank_n_r <= 1'b0;
			s1_cs_n_r <= 1'b1;
		end else if (!stall) begin
			// R1 capture every edge without stall
			s1_vld_r <= 1'b1;
			s1_idx_r <= s1_idx_nxt;
			s1_ovl_r <= s1_ovl_nxt;
			// R5 sample controls together
			s1_sync_n_r <= sync_n_in;
			s1_blank_n_r <= blank_n_in;
			s1_cs_n_r <= cs_n_in;
		end
	end

	// -----------------------------------------------------------------
	// Stage 2: colour lookup
	// -----------------------------------------------------------------
	// Overlay codes one to three never look at the index, so a stale index is harmless.
	reg [23:0] lookup;
	always @* begin
		// R2 R3 palette or overlay select
		case (s1_ovl_r)
			`PPP_OVL_PALETTE: lookup = pal_r[s1_idx_r];
			`PPP_OVL_COLOR1: lookup = ovl_r[1];
			`PPP_OVL_COLOR2: lookup = ovl_r[2];
			`PPP_OVL_COLOR3: lookup = ovl_r[3];
			default: lookup = `PPP_RST_WORD;
		endcase
	end

	// -----------------------------------------------------------------
	// Stage 2: blanking and register
	// -----------------------------------------------------------------
	reg [23:0] s2_rgb_nxt;
	// R6 R9 blank or cs forces black
	always @* begin
		s2_rgb_nxt = lookup;
		if (!s1_blank_n_r || !s1_cs_n_r)
			s2_rgb_nxt = `PPP_RST_WORD;
	end

	reg s2_vld_r;
	reg [23:0] s2_rgb_r;
	reg s2_sync_n_r;
	reg s2_blank_n_r;
	always @(posedge core_clk_in or negedge rst_n_r) begin
		if (!rst_n_r) begin
			s2_vld_r <= 1'b0;
			s2_rgb_r <= `PPP_RST_WORD;
			s2_sync_n_r <= 1'b0;
			s2_blank_n_r <= 1'b0;
		end else if (!stall) begin
			s2_vld_r <= s1_vld_r;
			s2_rgb_r <= s2_rgb_nxt;
			// R10 controls travel with colour
			s2_sync_n_r <= s1_sync_n_r;
			s2_blank_n_r <= s1_blank_n_r;
		end
	end

	// -----------------------------------------------------------------
	// Stage 3: buffer towards the converters
	// -----------------------------------------------------------------
	localparam SYNC_BIT = 25;
	localparam BLANK_BIT = 24;
	wire buf_in_ready;
	wire [25:0] buf_in;
	wire [25:0] buf_out;
	assign stall = s2_vld_r && !buf_in_ready;
	assign buf_in = {s2_sync_n_r, s2_blank_n_r, s2_rgb_r};

	ppp_skid_buffer #(
		.WIDTH(26)
	) u_buf (
		.core_clk_in(core_clk_in),
		.rst_n_in(rst_n_r),
		.in_valid_in(s2_vld_r),
		.in_ready_out(buf_in_ready),
		.in_data_in(buf_in),
		.out_valid_out(dac_valid_out),
		.out_ready_in(dac_ready_in),
		.out_data_out(buf_out)
	);

	// -----------------------------------------------------------------
	// Output byte split
	// -----------------------------------------------------------------
	wire [7:0] chan_byte [0:2];
	genvar ci;
	// R4 split word into bytes
	generate
		for (ci = 0; ci < 3; ci = ci + 1) begin : g_chan
			assign chan_byte[ci] = buf_out[`PPP_BLU_LSB + 8 * ci +: 8];
		end
	endgenerate
	assign red_current_out = chan_byte[2];
	assign green_current_out = chan_byte[1];
	assign blue_current_out = chan_byte[0];

	// -----------------------------------------------------------------
	// Sync and blank towards the converters
	// -----------------------------------------------------------------
	// R5 controls leave with colour
	assign sync_current_out = ~buf_out[SYNC_BIT];
	assign blank_n_out = buf_out[BLANK_BIT];
endmodule

// *** ppp_chk_chk.sv ***
`timescale 1ns/1ps
module ppp_chk (
	input wire core_clk_in, input wire reset_n_in, input wire dac_ready_in, input wire pix_ready_out,
	input wire dac_valid_out, input wire [7:0] red_current_out, input wire [7:0] green_current_out,
	input wire [7:0] blue_current_out, input wire sync_current_out, input wire blank_n_out
);
	wire v = dac_valid_out, rd = dac_ready_in, rn = reset_n_in;
	wire [23:0] c = {red_current_out, green_current_out, blue_current_out};
	default clocking @(posedge core_clk_in); endclocking
	default disable iff (!rn);
	AST_HOLD: assert property (v && !rd |=> v && $stable(c)) else $error("word moved");
	AST_SB: assert property ($changed({sync_current_out, blank_n_out}) |-> $past(!v || rd)) else $error("sb moved");
	AST_BLANK: assert property (v && !blank_n_out |-> c == 24'h000000) else $error("colour in blank");
	AST_FELL: assert property ($fell(v) |-> $past(rd)) else $error("word lost");
	AST_FULL: assert property (!pix_ready_out |-> v) else $error("refused while empty");
	AST_RV: assert property (disable iff (1'h0) !rn |-> !v) else $error("valid in reset");
	AST_RC: assert property (disable iff (1'h0) !rn |-> c == 24'h000000) else $error("colour in reset");
	AST_RP: assert property (disable iff (1'h0) !rn |-> pix_ready_out) else $error("busy in reset");
	cover property (v && !rd);
	cover property (!pix_ready_out);
	cover property (v && !blank_n_out);
endmodule
bind ppp_pixel_port ppp_chk ppp_chk_i (.*);

// *** ppp_fb_model.sv ***
`timescale 1ns/1ps
module ppp_fb_model (
	input wire clk_in, input wire rdy_in, output reg [7:0] idx_out, output reg [1:0] ol_out,
	output reg [1:0] sb_out, output reg cs_n_out
);
	reg ok;
	task idle;
		{idx_out, ol_out, sb_out, cs_n_out} <= 13'h0002;
	endtask
	task send(input [7:0] i, input [1:0] o, input [1:0] sb, input c);
		{idx_out, ol_out, sb_out, cs_n_out} <= {i, o, sb, c};
		ok = 1'h0;
		while (!ok) begin
			@(negedge clk_in);
			ok = rdy_in;
			@(posedge clk_in);
		end
	endtask
	initial idle;
endmodule

// *** palette_pixel_port_tb.sv ***
`timescale 1ns/1ps
module palette_pixel_port_tb;
	reg core_clk_in = 1'h0, reset_n_in = 1'h1, dac_ready_in = 1'h0, pal_wr_en_in = 1'h0, ovl_wr_en_in = 1'h0;
	reg [7:0] pal_wr_addr_in = 8'h00;
	reg [23:0] wr_data_in = 24'h000000;
	wire [7:0] pixel_index_in, red_current_out, green_current_out, blue_current_out;
	wire overlay_select_lsb_in, overlay_select_msb_in, sync_n_in, blank_n_in, cs_n_in;
	wire pix_ready_out, dac_valid_out, sync_current_out, blank_n_out;
	wire [1:0] ovl_wr_sel_in = pal_wr_addr_in[1:0];
	wire [25:0] w = {sync_current_out, blank_n_out, red_current_out, green_current_out, blue_current_out};
	reg [25:0] q [$];
	reg full = 1'h0;
	integer failures = 0, n_compared = 0, cyc = 0, stop = 0, k;
	ppp_pixel_port ppp_pixel_port_i (.*);
	ppp_fb_model ppp_fb_model_i (.clk_in(core_clk_in), .rdy_in(pix_ready_out), .idx_out(pixel_index_in),
		.ol_out({overlay_select_msb_in, overlay_select_lsb_in}), .sb_out({sync_n_in, blank_n_in}), .cs_n_out(cs_n_in));
	initial forever #2.5 core_clk_in = ~core_clk_in;
	// Idle pixels carry sync low, blank high and black, so they are skipped.
	always @(posedge core_clk_in) begin
		cyc <= cyc + 1;
		dac_ready_in <= cyc >= stop;
		if (!pix_ready_out) full <= 1'h1;
		if (dac_valid_out && dac_ready_in && w !== 26'h3000000)
			chk("word", q.size() ? q.pop_front() : 26'h3ffffff, w);
	end
	task chk(input [31:0] n, input [25:0] e, input [25:0] s);
		n_compared = n_compared + 1;
		if (s !== e) begin
			failures = failures + 1;
			$display("MISMATCH %0s exp %h got %h", n, e, s);
		end
	endtask
	task px(input [7:0] i, input [1:0] o, input [1:0] sb, input c, input [23:0] d);
		q.push_back({!sb[1], sb[0], (sb[0] && c) ? d : 24'h000000});
		ppp_fb_model_i.send(i, o, sb, c);
	endtask
	task wr(input p, input [7:0] a, input [23:0] d);
		@(posedge core_clk_in);
		{pal_wr_en_in, ovl_wr_en_in, pal_wr_addr_in, wr_data_in} <= {p, !p, a, d};
		@(posedge core_clk_in);
		{pal_wr_en_in, ovl_wr_en_in} <= 2'h0;
	endtask
	task drain(input [31:0] n);
		ppp_fb_model_i.idle;
		for (k = 0; k < 99 && q.size(); k = k + 1)
			@(posedge core_clk_in);
		chk(n, 26'h0, 26'(q.size()));
		$display("test %0s done", n);
	endtask
	task t_pal;
		wr(1'h1, 8'h00, 24'h123456);
		wr(1'h1, 8'hff, 24'habcdef);
		px(8'h00, 2'h0, 2'h3, 1'h1, 24'h123456);
		px(8'hff, 2'h0, 2'h3, 1'h1, 24'habcdef);
		px(8'h5a, 2'h0, 2'h3, 1'h1, 24'h000000);
		for (k = 0; k < 4; k = k + 1)
			px(8'hff, 2'h0, k[1:0], 1'h1, 24'habcdef);
		drain("pal");
	endtask
	task t_ovl;
		for (k = 1; k < 4; k = k + 1)
			wr(1'h0, k[7:0], {3{k[7:0]}});
		for (k = 1; k < 4; k = k + 1)
			px(8'hff, k[1:0], 2'h1, 1'h1, {3{k[7:0]}});
		px(8'hff, 2'h2, 2'h3, 1'h0, 24'h000000);
		drain("ovl");
	endtask
	task t_stall;
		stop = cyc + 30;
		for (k = 0; k < 8; k = k + 1)
			px(k[7:0], 2'h3, 2'h3, 1'h1, 24'h030303);
		chk("full", 26'h1, {25'h0, full});
		drain("stl");
	endtask
	task print_verdict;
		$display("compared %0d failures %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	initial begin
		reset_n_in <= 1'h0;
		repeat (2) @(posedge core_clk_in);
		reset_n_in <= 1'h1;
		repeat (3) @(posedge core_clk_in);
		t_pal;
		t_ovl;
		t_stall;
		print_verdict;
	end
	initial begin
		#20000;
		failures = failures + 1;
		print_verdict;
	end
endmodule
